// file: logic/scan_tap.v
`timescale 1ns/1ns
`include "scan_port_consts.vh"
module scan_tap #(
   parameter [2:0] DENSITY = 3'd0,
   parameter [6:0] USER_BITS = 7'h00
) (
   // clock and reset
   input wire clk_i,
   input wire reset_i,
   // test pins
   input wire tck_i,
   input wire tms_i,
   input wire tdi_i,
   output reg tdo_o,
   output reg tdo_oe_o,
   // device pins and core
   input wire [`BSR_MAX-1:0] pin_in_i,
   input wire [`BSR_MAX-1:0] core_out_i,
   input wire config_busy_i,
   output reg [`BSR_MAX-1:0] pin_out_o,
   output reg test_mode_o,
   // configuration stream
   output reg cfg_bit_o,
   output reg cfg_bit_valid_o,
   output reg cfg_start_o
);
   // controller states, one-hot
   localparam [15:0] S_RESET = 16'h0001, S_IDLE = 16'h0002, S_SELDR = 16'h0004,
      S_CAPDR = 16'h0008, S_SHDR = 16'h0010, S_EX1DR = 16'h0020, S_PADR = 16'h0040,
      S_EX2DR = 16'h0080, S_UPDR = 16'h0100, S_SELIR = 16'h0200, S_CAPIR = 16'h0400,
      S_SHIR = 16'h0800, S_EX1IR = 16'h1000, S_PAIR = 16'h2000, S_EX2IR = 16'h4000,
      S_UPIR = 16'h8000;

   // boundary length for the chosen density
   function [10:0] bsr_len;
      input [2:0] d;
      begin
         case (d)
            3'd0: bsr_len = 11'd`BSR_LEN_0;
            3'd1: bsr_len = 11'd`BSR_LEN_1;
            3'd2: bsr_len = 11'd`BSR_LEN_2;
            3'd3: bsr_len = 11'd`BSR_LEN_3;
            default: bsr_len = 11'd`BSR_LEN_4;
         endcase
      end
   endfunction

   wire [3:0] pins_s;
   wire tck_s = pins_s[0];
   wire tms_s = pins_s[1];
   wire tdi_s = pins_s[2];
   wire busy_s = pins_s[3];
   scan_pin_sync u_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .raw_i({config_busy_i, tdi_i, tms_i, tck_i}),
      .sync_o(pins_s)
   );

   reg tck_q;
   reg [15:0] state_q;
   reg [15:0] state_d;
   reg [`IR_LEN-1:0] ir_sh_q;
   reg [`IR_LEN-1:0] ir_q;
   reg bypass_q;
   reg [`USER_LEN-1:0] dr32_q;
   reg [`BSR_MAX-1:0] bsr_q;
   reg [`BSR_MAX-1:0] bsr_upd_q;
   reg tdo_d;

   wire rise = tck_s & ~tck_q;
   wire fall = ~tck_s & tck_q;
   wire [10:0] blen = bsr_len(DENSITY);
   wire is_ext = (ir_q == `OP_EXTEST);
   wire is_smp = (ir_q == `OP_SAMPLE);
   wire is_id = (ir_q == `OP_IDCODE);
   wire is_usr = (ir_q == `OP_USERCODE);
   wire is_cfg = (ir_q == `OP_CFG_LOAD);
   wire is_bsr = is_ext | is_smp;

   // next state from mode select
   always @* begin
      state_d = S_RESET;
      case (state_q)
         S_RESET: state_d = tms_s ? S_RESET : S_IDLE;
         S_IDLE: state_d = tms_s ? S_SELDR : S_IDLE;
         S_SELDR: state_d = tms_s ? S_SELIR : S_CAPDR;
         S_CAPDR: state_d = tms_s ? S_EX1DR : S_SHDR;
         S_SHDR: state_d = tms_s ? S_EX1DR : S_SHDR;
         S_EX1DR: state_d = tms_s ? S_UPDR : S_PADR;
         S_PADR: state_d = tms_s ? S_EX2DR : S_PADR;
         S_EX2DR: state_d = tms_s ? S_UPDR : S_SHDR;
         S_UPDR: state_d = tms_s ? S_SELDR : S_IDLE;
         S_SELIR: state_d = tms_s ? S_RESET : S_CAPIR;
         S_CAPIR: state_d = tms_s ? S_EX1IR : S_SHIR;
         S_SHIR: state_d = tms_s ? S_EX1IR : S_SHIR;
         S_EX1IR: state_d = tms_s ? S_UPIR : S_PAIR;
         S_PAIR: state_d = tms_s ? S_EX2IR : S_PAIR;
         S_EX2IR: state_d = tms_s ? S_UPIR : S_SHIR;
         S_UPIR: state_d = tms_s ? S_SELDR : S_IDLE;
         default: state_d = S_RESET;
      endcase
   end

   // selected register's serial output
   always @* begin
      tdo_d = bypass_q;
      if (state_q == S_SHIR) begin
         tdo_d = ir_sh_q[0];
      end else if (is_id | is_usr) begin
         tdo_d = dr32_q[0];
      end else if (is_bsr) begin
         tdo_d = bsr_q[0];
      end
   end

   // controller and registers on test clock rise, update latch on test clock fall
   always @(posedge clk_i) begin
      if (reset_i) begin
         tck_q <= 1'b0;
         state_q <= S_RESET;
         ir_sh_q <= {`IR_LEN{1'b0}};
         ir_q <= `OP_IDCODE;
         bypass_q <= 1'b0;
         dr32_q <= {`USER_LEN{1'b0}};
         bsr_q <= {`BSR_MAX{1'b0}};
         bsr_upd_q <= {`BSR_MAX{1'b0}};
         cfg_bit_o <= 1'b0;
         cfg_bit_valid_o <= 1'b0;
         cfg_start_o <= 1'b0;
      end else begin
         tck_q <= tck_s;
         cfg_bit_valid_o <= 1'b0;
         cfg_start_o <= 1'b0;
         if (rise) begin
            state_q <= state_d;
            case (state_q)
               S_RESET: ir_q <= `OP_IDCODE;
               S_CAPIR: ir_sh_q <= `IR_CAPTURE;
               S_SHIR: ir_sh_q <= {tdi_s, ir_sh_q[`IR_LEN-1:1]};
               S_UPIR: begin
                  // scan instructions refused while configuring
                  if (busy_s && (ir_sh_q == `OP_EXTEST || ir_sh_q == `OP_SAMPLE)) begin
                     ir_q <= `OP_BYPASS;
                  end else begin
                     ir_q <= ir_sh_q;
                  end
                  if (ir_sh_q == `OP_CFG_START) begin
                     cfg_start_o <= 1'b1;
                  end
               end
               S_CAPDR: begin
                  bypass_q <= 1'b0;
                  if (is_id) begin
                     dr32_q <= `ID_VALUE;
                  end else if (is_usr) begin
                     dr32_q <= {`USER_FIXED, USER_BITS};
                  end else if (is_bsr) begin
                     bsr_q <= pin_in_i;
                  end
               end
               S_SHDR: begin
                  bypass_q <= tdi_s;
                  dr32_q <= {tdi_s, dr32_q[`USER_LEN-1:1]};
                  if (is_bsr) begin
                     bsr_q <= bsr_q >> 1;
                     bsr_q[blen-11'd1] <= tdi_s;
                  end
                  if (is_cfg) begin
                     cfg_bit_o <= tdi_s;
                     cfg_bit_valid_o <= 1'b1;
                  end
               end
               default: begin
               end
            endcase
         end
         // preload or test pattern update on the falling edge
         if (fall && state_q == S_UPDR && is_bsr) begin
            bsr_upd_q <= bsr_q;
         end
      end
   end

   // data out and enable on test clock fall, pins from update latch under EXTEST, else from core
   always @(posedge clk_i) begin
      if (reset_i) begin
         tdo_o <= 1'b0;
         tdo_oe_o <= 1'b0;
         pin_out_o <= {`BSR_MAX{1'b0}};
         test_mode_o <= 1'b0;
      end else begin
         if (fall) begin
            tdo_o <= tdo_d;
            tdo_oe_o <= (state_q == S_SHIR) | (state_q == S_SHDR);
         end
         test_mode_o <= is_ext;
         pin_out_o <= is_ext ? bsr_upd_q : core_out_i;
      end
   end
endmodule // scan_tap

// file: logic/scan_port_consts.vh
`ifndef SCAN_PORT_CONSTS_VH
`define SCAN_PORT_CONSTS_VH
// instruction register
`define IR_LEN 10
`define IR_CAPTURE 10'h001
// instruction codes (arbitrary but fixed)
`define OP_EXTEST 10'h000
`define OP_SAMPLE 10'h055
`define OP_IDCODE 10'h059
`define OP_USERCODE 10'h079
`define OP_CFG_LOAD 10'h002
`define OP_CFG_START 10'h003
`define OP_BYPASS 10'h3FF
// data registers
`define USER_LEN 32
`define USER_FIELD_LEN 7
`define USER_FIXED_LEN 25
// arbitrary identification values, not of any maker
`define ID_VALUE 32'h0ABC1001
`define USER_FIXED 25'h0123456
// boundary lengths per density
`define BSR_LEN_0 690
`define BSR_LEN_1 798
`define BSR_LEN_2 1050
`define BSR_LEN_3 1308
`define BSR_LEN_4 1446
`define BSR_MAX 1446
`define BSR_LEN_SEL 4
`endif

// file: logic/scan_pin_sync.v
`timescale 1ns/1ns
// two-flop synchroniser for the test pins and the config busy input
module scan_pin_sync (
   // clock and reset
   input wire clk_i,
   input wire reset_i,
   // pins
   input wire [3:0] raw_i,
   output reg [3:0] sync_o
);
   reg [3:0] meta_q;
   // first stage feeds only the second
   always @(posedge clk_i) begin
      if (reset_i) begin
         meta_q <= 4'h0;
         sync_o <= 4'h0;
      end else begin
         meta_q <= raw_i;
         sync_o <= meta_q;
      end
   end
endmodule // scan_pin_sync

// file: dv/scan_tap_checker.sv
`timescale 1ns/1ns
`include "scan_port_consts.vh"
module scan_tap_checker (
   // clock and reset
   input wire clk_i,
   input wire reset_i,
   // watched ports
   input wire tck_i,
   input wire config_busy_i,
   input wire tdo_o,
   input wire tdo_oe_o,
   input wire test_mode_o,
   input wire cfg_bit_valid_o,
   input wire cfg_start_o,
   input wire [`BSR_MAX-1:0] core_out_i,
   input wire [`BSR_MAX-1:0] pin_out_o
);
   // all checks on the system clock
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   property p_bit_pulse; cfg_bit_valid_o |=> !cfg_bit_valid_o; endproperty
   a_bit_pulse: assert property (p_bit_pulse) else $error("bit strobe long");
   property p_start_pulse; cfg_start_o |=> !cfg_start_o; endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start long");
   property p_bit_rise; cfg_bit_valid_o |-> tdo_oe_o && $past(tck_i, 2); endproperty
   a_bit_rise: assert property (p_bit_rise) else $error("strobe off rise");
   property p_tdo_fall; $changed(tdo_o) |-> !$past(tck_i, 2); endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("tdo off fall");
   property p_oe_fall; $changed(tdo_oe_o) |-> !$past(tck_i, 2); endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("enable off fall");
   property p_busy; $rose(test_mode_o) |-> !$past(config_busy_i, 4); endproperty
   a_busy: assert property (p_busy) else $error("test while busy");
   property p_no_bits; cfg_bit_valid_o |-> !test_mode_o; endproperty
   a_no_bits: assert property (p_no_bits) else $error("bits in test");
   property p_core; !test_mode_o && !$past(test_mode_o) && !$past(test_mode_o, 2)
      && !$past(reset_i) |-> pin_out_o == $past(core_out_i); endproperty
   a_core: assert property (p_core) else $error("core not on pins");
endmodule // scan_tap_checker
bind scan_tap scan_tap_checker scan_tap_checker_inst (.clk_i, .reset_i, .tck_i, .config_busy_i,
   .tdo_o, .tdo_oe_o, .test_mode_o, .cfg_bit_valid_o, .cfg_start_o, .core_out_i, .pin_out_o);

// file: dv/scan_host.sv
`timescale 1ns/1ns
module scan_host (
   // test pins, tck idles low outside frames
   output logic tck_o = 1'b0,
   output logic tms_o = 1'b1,
   output logic tdi_o = 1'b0,
   input wire tdo_i
);
   // one tck period, tdo taken just before the rise
   task automatic bit_cyc(input logic m, d, output logic q);
      tms_o = m;
      tdi_o = d;
      #20 q = tdo_i;
      #4 tck_o = 1'b1;
      #24 tck_o = 1'b0;
   endtask
   // five high mode bits reach reset, then idle
   task automatic tap_reset();
      logic q;
      repeat (5) bit_cyc(1'b1, 1'b0, q);
      bit_cyc(1'b0, 1'b0, q);
   endtask
   // idle to idle scan of n bits, lsb first
   task automatic scan(input logic ir, input int n, input logic [1445:0] din,
      output logic [1445:0] dout);
      logic q;
      dout = '0;
      bit_cyc(1'b1, 1'b0, q);
      if (ir) bit_cyc(1'b1, 1'b0, q);
      bit_cyc(1'b0, 1'b0, q);
      bit_cyc(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) bit_cyc(i == n - 1, din[i], dout[i]);
      bit_cyc(1'b1, 1'b0, q);
      bit_cyc(1'b0, 1'b0, q);
   endtask
endmodule // scan_host

// file: dv/scan_tap_tb_top.sv
`timescale 1ns/1ns
`include "scan_port_consts.vh"
module scan_tap_tb_top;
   logic clk_i = 1'b0, reset_i = 1'b1, config_busy_i = 1'b0;
   logic tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, test_mode_o, cfg_bit_o, cfg_bit_valid_o, cfg_start_o;
   logic [1445:0] pin_in_i = {723{2'b10}}, core_out_i = {723{2'b01}}, pin_out_o, d, pat;
   int compares = 0, miscompares = 0, pulses = 0, starts = 0;
   logic [39:0] cfg_seen = '0;
   typedef struct {logic [9:0] op; logic [31:0] exp;} row_t;
   row_t rows [4];
   always #2 clk_i = ~clk_i;
   scan_tap #(.DENSITY(3'd0), .USER_BITS(7'h5A)) scan_tap_inst (.clk_i, .reset_i, .tck_i, .tms_i,
      .tdi_i, .tdo_o, .tdo_oe_o, .pin_in_i, .core_out_i, .config_busy_i, .pin_out_o, .test_mode_o,
      .cfg_bit_o, .cfg_bit_valid_o, .cfg_start_o);
   scan_host scan_host_inst (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o));
   // count config strobes and collect the streamed bits, first bit ends lowest
   always @(posedge clk_i) begin
      if (cfg_bit_valid_o === 1'b1) cfg_seen = {cfg_bit_o, cfg_seen[39:1]};
      pulses += (cfg_bit_valid_o === 1'b1);
      starts += (cfg_start_o === 1'b1);
   end
   task automatic check(input string what, input logic [31:0] exp, got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic ir(input logic [9:0] op);
      scan_host_inst.scan(1'b1, 10, {1436'h0, op}, d);
      check("ir capture", 32'h001, {22'h0, d[9:0]});
   endtask
   task automatic summarize();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // main sequence
   initial begin
      rows = '{'{`OP_IDCODE, `ID_VALUE}, '{`OP_USERCODE, {`USER_FIXED, 7'h5A}},
         '{`OP_BYPASS, 32'h87A55A3C}, '{10'h1F0, 32'h87A55A3C}};
      pat = {723{2'b01}};
      repeat (5) @(posedge clk_i);
      #1 reset_i = 1'b0;
      repeat (4) @(posedge clk_i);
      #1 scan_host_inst.tap_reset();
      scan_host_inst.scan(1'b0, 32, '0, d);
      check("id after reset", `ID_VALUE, d[31:0]);
      $display("reset done");
      foreach (rows[i]) begin
         ir(rows[i].op);
         scan_host_inst.scan(1'b0, 32, 1446'hC3D2AD1E, d);
         check("dr row", rows[i].exp, d[31:0]);
      end
      $display("rows done");
      ir(`OP_SAMPLE);
      scan_host_inst.scan(1'b0, 691, pat, d);
      check("sample capture", 1, d[689:0] === pin_in_i[689:0]);
      check("boundary length", 1, d[690]);
      ir(`OP_EXTEST);
      check("test mode", 1, test_mode_o);
      check("preload on pins", 1, pin_out_o[689:0] === pat[690:1]);
      scan_host_inst.scan(1'b0, 690, pat, d);
      check("extest capture", 1, d[689:0] === pin_in_i[689:0]);
      check("extest drive", 1, pin_out_o[689:0] === pat[689:0]);
      ir(`OP_IDCODE);
      check("core on pins", 1, pin_out_o === core_out_i);
      @(posedge clk_i) #1 config_busy_i = 1'b1;
      ir(`OP_EXTEST);
      check("refused mode", 0, test_mode_o);
      scan_host_inst.scan(1'b0, 32, 1446'hC3D2AD1E, d);
      check("refused bypass", 32'h87A55A3C, d[31:0]);
      @(posedge clk_i) #1 config_busy_i = 1'b0;
      ir(`OP_CFG_LOAD);
      pulses = 0;
      scan_host_inst.scan(1'b0, 40, pat, d);
      check("config bits", 40, pulses);
      check("config data low", pat[31:0], cfg_seen[31:0]);
      check("config data high", {24'h0, pat[39:32]}, {24'h0, cfg_seen[39:32]});
      check("enable idle", 0, tdo_oe_o);
      starts = 0;
      ir(`OP_CFG_START);
      check("config start", 1, starts);
      // mid-run reset returns the port to identification
      @(posedge clk_i) #1 reset_i = 1'b1;
      repeat (5) @(posedge clk_i);
      #1 reset_i = 1'b0;
      check("reset enable", 0, tdo_oe_o);
      check("reset data out", 0, tdo_o);
      check("reset mode", 0, test_mode_o);
      repeat (4) @(posedge clk_i);
      #1 scan_host_inst.tap_reset();
      scan_host_inst.scan(1'b0, 32, '0, d);
      check("id after mid reset", `ID_VALUE, d[31:0]);
      $display("mid reset done");
      $display("edge cases done");
      summarize();
   end
   // watchdog
   initial begin
      #400000;
      miscompares++;
      summarize();
   end
endmodule // scan_tap_tb_top
